// *** include/fir_pkg.sv ***
/*
 * Constants, opcodes, command codes and state encoding for the host-side
 * identification readout controller of a serial flash.
 * Assumes the system clock runs at the rate given by CLK_PERIOD_NS.
 */
package fir_pkg;

	// System clock
	localparam int unsigned CLK_PERIOD_NS = 50;

	// Device delays in nanoseconds (plain defaults, no figure is printed)
	localparam int unsigned POWER_DOWN_ENTRY_DELAY_NS = 3000;
	localparam int unsigned POWER_UP_RELEASE_DELAY_NS = 3000;
	localparam int unsigned RELEASE_WITH_ID_DELAY_NS = 1800;
	localparam int unsigned CS_HIGH_MIN_NS = 100;

	// Least times round up to whole cycles
	localparam logic [15:0] POWER_DOWN_ENTRY_CYC =
		16'((POWER_DOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] POWER_UP_RELEASE_CYC =
		16'((POWER_UP_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] RELEASE_WITH_ID_CYC =
		16'((RELEASE_WITH_ID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CS_HIGH_MIN_CYC =
		16'((CS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Instruction opcodes
	localparam logic [7:0] OPC_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OPC_RELEASE = 8'hab;
	localparam logic [7:0] OPC_MFR_ID = 8'h90;
	localparam logic [7:0] OPC_MFR_ID_DUAL = 8'h92;
	localparam logic [7:0] OPC_MFR_ID_QUAD = 8'h94;
	localparam logic [7:0] OPC_UNIQUE_ID = 8'h4b;
	localparam logic [7:0] OPC_STD_ID = 8'h9f;
	localparam logic [7:0] OPC_PARAM_READ = 8'h5a;

	// Continuous-read mode byte, upper nibble all ones
	localparam logic [7:0] MODE_BITS = 8'hf0;

	// Lane widths
	localparam logic [2:0] W_SINGLE = 3'h1;
	localparam logic [2:0] W_DUAL = 3'h2;
	localparam logic [2:0] W_QUAD = 3'h4;

	// Clock counts of each phase
	localparam logic [5:0] OPC_CLK_SINGLE = 6'h08;
	localparam logic [5:0] OPC_CLK_QUAD = 6'h02;
	localparam logic [5:0] DEVID_DUMMY_CLK_SINGLE = 6'h18;
	localparam logic [5:0] DEVID_DUMMY_CLK_QUAD = 6'h06;
	localparam logic [5:0] ADDR_CLK_SINGLE = 6'h18;
	localparam logic [5:0] ADDR_MODE_CLK_DUAL = 6'h10;
	localparam logic [5:0] DUMMY_ADDR_MODE_CLK_QUAD = 6'h0c;
	localparam logic [5:0] UID_DUMMY_CLK = 6'h20;
	localparam logic [5:0] PARAM_DUMMY_CLK = 6'h08;

	// Reset values of the pins: io2/io3 serve as write protect and hold
	localparam logic [3:0] IO_IDLE_O = 4'hc;
	localparam logic [3:0] IO_IDLE_OE = 4'hc;

	typedef enum logic [3:0] {
		FIR_CMD_POWER_DOWN = 4'h0,
		FIR_CMD_RELEASE = 4'h1,
		FIR_CMD_DEVICE_ID = 4'h2,
		FIR_CMD_MFR_ID = 4'h3,
		FIR_CMD_MFR_ID_DUAL = 4'h4,
		FIR_CMD_MFR_ID_QUAD = 4'h5,
		FIR_CMD_UNIQUE_ID = 4'h6,
		FIR_CMD_STD_ID = 4'h7,
		FIR_CMD_PARAM_READ = 4'h8
	} fir_cmd_e;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_OPC = 7'b0000010,
		ST_PAY = 7'b0000100,
		ST_DUM = 7'b0001000,
		ST_RD = 7'b0010000,
		ST_END = 7'b0100000,
		ST_WAIT = 7'b1000000
	} fir_state_e;

endpackage : fir_pkg

// *** logic/fir_host.sv ***
/*
 * Host-side controller that issues the power-down, release and
 * identification instructions of a serial flash and returns read bytes.
 * Assumes one system clock domain; the serial clock is divided down from
 * it and driven out; pin inputs arrive asynchronously and are synchronised.
 */
// Function
// - Release opcode alone then chip select high ends power-down.
// - Host holds chip select high for the whole power-up release delay.
// - Release opcode plus three dummy bytes returns device ID, MSB first.
// - After ID-form release from power-down, hold chip select high longer.
// - Opcode 90h with zero address returns manufacturer then device ID.
// - Opcode 92h sends address two bits per clock, reads two bits.
// - Opcode 94h: four dummy clocks, address by nibbles, reads nibbles.
// - Dual and quad ID reads send mode bits with upper nibble ones.
// - Unique ID opcode, four dummy bytes, then a 64-bit identifier.
// - Parameter read: opcode, address, eight dummy clocks, then data.
// - Parameter address upper sixteen bits zero; low byte picks start.
`timescale 1ns/1ps
`default_nettype none

module fir_host
	import fir_pkg::*;
#(
	parameter int unsigned HALF_PERIOD = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [3:0] cmd_sel,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	input wire logic qpi_mode,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	output logic done,
	output logic cmd_err,
	output logic powered_down,
	output logic spi_cs_n,
	output logic spi_sck,
	output logic [3:0] spi_io_o,
	output logic [3:0] spi_io_oe,
	input wire logic [3:0] spi_io_i
);

	generate
		// The input synchroniser lags four cycles, so a serial clock
		// period must be at least six system clocks to sample on time.
		if (HALF_PERIOD < 3 || HALF_PERIOD > 255) begin : g_chk
			$error("HALF_PERIOD must lie in 3..255");
		end
	endgenerate

	localparam logic [7:0] HALF_LAST = 8'(HALF_PERIOD - 1);

	// Drive the lanes from the top of the shift register at width w
	function automatic logic [7:0] lane_drive(input logic [55:0] sh,
		input logic [2:0] w);
		case (w)
			W_QUAD: lane_drive = {4'hf, sh[55:52]};
			W_DUAL: lane_drive = {4'hf, 2'b11, sh[55:54]};
			default: lane_drive = {4'hd, 3'b110, sh[55]};
		endcase
	endfunction : lane_drive

	// Release the lanes the device drives at width w
	function automatic logic [7:0] lane_release(input logic [2:0] w);
		case (w)
			W_QUAD: lane_release = 8'h00;
			default: lane_release = {IO_IDLE_OE, IO_IDLE_O};
		endcase
	endfunction : lane_release

	function automatic logic [5:0] byte_clks(input logic [2:0] w);
		case (w)
			W_QUAD: byte_clks = 6'h02;
			W_DUAL: byte_clks = 6'h04;
			default: byte_clks = 6'h08;
		endcase
	endfunction : byte_clks

	function automatic fir_state_e next_phase(input logic pay,
		input logic dum, input logic rd);
		if (pay) begin
			next_phase = ST_PAY;
		end else if (dum) begin
			next_phase = ST_DUM;
		end else if (rd) begin
			next_phase = ST_RD;
		end else begin
			next_phase = ST_END;
		end
	endfunction : next_phase

	function automatic logic cmd_refused(input logic [3:0] sel,
		input logic qpi, input logic pd, input logic [7:0] len);
		logic rd;
		logic qpi_ok;
		logic pd_ok;
		rd = 1'b1;
		qpi_ok = 1'b0;
		pd_ok = 1'b0;
		case (sel)
			FIR_CMD_POWER_DOWN: begin
				rd = 1'b0;
				qpi_ok = 1'b1;
			end
			FIR_CMD_RELEASE: begin
				rd = 1'b0;
				qpi_ok = 1'b1;
				pd_ok = 1'b1;
			end
			FIR_CMD_DEVICE_ID: begin
				qpi_ok = 1'b1;
				pd_ok = 1'b1;
			end
			FIR_CMD_STD_ID: qpi_ok = 1'b1;
			default: qpi_ok = 1'b0;
		endcase
		cmd_refused = (sel > FIR_CMD_PARAM_READ)
			| (qpi & ~qpi_ok)
			| (pd & ~pd_ok)
			| (rd & (len == 8'h00));
	endfunction : cmd_refused

	// Input synchroniser
	logic [3:0] s1_r, s2_r, s3_r, in_r;
	logic [3:0] in_nxt;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			in_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : in_r[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			in_r <= 4'h0;
		end else begin
			s1_r <= spi_io_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			in_r <= in_nxt;
		end
	end

	// Sequencer state
	fir_state_e state_r, state_nxt, tgt;
	logic [7:0] div_r, div_nxt;
	logic sck_r, sck_nxt;
	logic cs_n_r, cs_n_nxt;
	logic [3:0] io_o_r, io_o_nxt, io_oe_r, io_oe_nxt;
	logic [55:0] sh_r, sh_nxt, sh_sh;
	logic [5:0] cnt_r, cnt_nxt;
	logic [5:0] pay_n_r, pay_n_nxt, dum_n_r, dum_n_nxt;
	logic [2:0] pay_w_r, pay_w_nxt, rd_w_r, rd_w_nxt, opw_r, opw_nxt;
	logic [2:0] cur_w;
	logic rd_en_r, rd_en_nxt;
	logic [7:0] bytes_r, bytes_nxt;
	logic [7:0] rx_r, rx_nxt, rx_in;
	logic [15:0] wait_r, wait_nxt, wait_len_r, wait_len_nxt;
	logic pd_r, pd_nxt, pd_after_r, pd_after_nxt;
	logic ready_r, ready_nxt;
	logic [7:0] rsp_data_r, rsp_data_nxt;
	logic rsp_valid_r, rsp_valid_nxt, done_r, done_nxt, err_r, err_nxt;
	logic tick;
	logic [7:0] opc;
	logic [47:0] payload;
	logic [7:0] lanes;

	always_comb begin
		state_nxt = state_r;
		div_nxt = 8'h00;
		sck_nxt = sck_r;
		cs_n_nxt = cs_n_r;
		io_o_nxt = io_o_r;
		io_oe_nxt = io_oe_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		pay_n_nxt = pay_n_r;
		dum_n_nxt = dum_n_r;
		pay_w_nxt = pay_w_r;
		rd_w_nxt = rd_w_r;
		opw_nxt = opw_r;
		rd_en_nxt = rd_en_r;
		bytes_nxt = bytes_r;
		rx_nxt = rx_r;
		wait_nxt = wait_r;
		wait_len_nxt = wait_len_r;
		pd_nxt = pd_r;
		pd_after_nxt = pd_after_r;
		ready_nxt = ready_r;
		rsp_data_nxt = rsp_data_r;
		rsp_valid_nxt = 1'b0;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		tgt = state_r;
		opc = OPC_STD_ID;
		payload = 48'h0;
		lanes = 8'h00;
		tick = (div_r == HALF_LAST);
		case (state_r)
			ST_OPC: cur_w = opw_r;
			ST_PAY: cur_w = pay_w_r;
			default: cur_w = rd_w_r;
		endcase
		sh_sh = sh_r << cur_w;
		case (rd_w_r)
			W_QUAD: rx_in = {rx_r[3:0], in_r[3:0]};
			W_DUAL: rx_in = {rx_r[5:0], in_r[1:0]};
			default: rx_in = {rx_r[6:0], in_r[1]};
		endcase

		case (state_r)
			ST_IDLE: begin
				if (cmd_valid && ready_r) begin
					if (cmd_refused(cmd_sel, qpi_mode, pd_r, cmd_len)) begin
						err_nxt = 1'b1;
					end else begin
						ready_nxt = 1'b0;
						pay_n_nxt = 6'h00;
						pay_w_nxt = W_SINGLE;
						dum_n_nxt = 6'h00;
						rd_en_nxt = 1'b1;
						rd_w_nxt = W_SINGLE;
						wait_len_nxt = CS_HIGH_MIN_CYC;
						pd_after_nxt = pd_r;
						bytes_nxt = cmd_len;
						case (cmd_sel)
							FIR_CMD_POWER_DOWN: begin
								opc = OPC_POWER_DOWN;
								rd_en_nxt = 1'b0;
								wait_len_nxt = POWER_DOWN_ENTRY_CYC;
								pd_after_nxt = 1'b1;
							end
							FIR_CMD_RELEASE: begin
								opc = OPC_RELEASE;
								rd_en_nxt = 1'b0;
								wait_len_nxt = POWER_UP_RELEASE_CYC;
								pd_after_nxt = 1'b0;
							end
							FIR_CMD_DEVICE_ID: begin
								opc = OPC_RELEASE;
								pay_n_nxt = qpi_mode ? DEVID_DUMMY_CLK_QUAD :
									DEVID_DUMMY_CLK_SINGLE;
								pay_w_nxt = qpi_mode ? W_QUAD : W_SINGLE;
								rd_w_nxt = qpi_mode ? W_QUAD : W_SINGLE;
								if (pd_r) begin
									wait_len_nxt = RELEASE_WITH_ID_CYC;
								end
								pd_after_nxt = 1'b0;
							end
							FIR_CMD_MFR_ID: begin
								opc = OPC_MFR_ID;
								pay_n_nxt = ADDR_CLK_SINGLE;
							end
							FIR_CMD_MFR_ID_DUAL: begin
								opc = OPC_MFR_ID_DUAL;
								payload = {24'h0, MODE_BITS, 16'h0};
								pay_n_nxt = ADDR_MODE_CLK_DUAL;
								pay_w_nxt = W_DUAL;
								rd_w_nxt = W_DUAL;
							end
							FIR_CMD_MFR_ID_QUAD: begin
								opc = OPC_MFR_ID_QUAD;
								payload = {16'h0, 24'h0, MODE_BITS};
								pay_n_nxt = DUMMY_ADDR_MODE_CLK_QUAD;
								pay_w_nxt = W_QUAD;
								rd_w_nxt = W_QUAD;
							end
							FIR_CMD_UNIQUE_ID: begin
								opc = OPC_UNIQUE_ID;
								pay_n_nxt = UID_DUMMY_CLK;
							end
							FIR_CMD_PARAM_READ: begin
								opc = OPC_PARAM_READ;
								payload = {16'h0, cmd_addr, 24'h0};
								pay_n_nxt = ADDR_CLK_SINGLE;
								dum_n_nxt = PARAM_DUMMY_CLK;
							end
							default: begin
								opc = OPC_STD_ID;
								rd_w_nxt = qpi_mode ? W_QUAD : W_SINGLE;
							end
						endcase
						opw_nxt = qpi_mode ? W_QUAD : W_SINGLE;
						cnt_nxt = qpi_mode ? OPC_CLK_QUAD : OPC_CLK_SINGLE;
						sh_nxt = {opc, payload};
						lanes = lane_drive(sh_nxt, opw_nxt);
						io_oe_nxt = lanes[7:4];
						io_o_nxt = lanes[3:0];
						cs_n_nxt = 1'b0;
						state_nxt = ST_OPC;
					end
				end
			end
			ST_OPC, ST_PAY, ST_DUM, ST_RD: begin
				div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
				if (tick && !sck_r) begin
					sck_nxt = 1'b1;
				end else if (tick) begin
					sck_nxt = 1'b0;
					sh_nxt = sh_sh;
					cnt_nxt = cnt_r - 6'h01;
					if (state_r == ST_RD) begin
						rx_nxt = rx_in;
					end
					if (cnt_r == 6'h01) begin
						case (state_r)
							ST_OPC: tgt = next_phase(pay_n_r != 6'h00,
								dum_n_r != 6'h00, rd_en_r);
							ST_PAY: tgt = next_phase(1'b0,
								dum_n_r != 6'h00, rd_en_r);
							ST_DUM: tgt = next_phase(1'b0, 1'b0, rd_en_r);
							default: begin
								rsp_data_nxt = rx_in;
								rsp_valid_nxt = 1'b1;
								bytes_nxt = bytes_r - 8'h01;
								// Device repeats its ID until deselected
								tgt = (bytes_r == 8'h01) ? ST_END : ST_RD;
							end
						endcase
						state_nxt = tgt;
						case (tgt)
							ST_PAY: begin
								cnt_nxt = pay_n_r;
								lanes = lane_drive(sh_sh, pay_w_r);
							end
							ST_DUM: begin
								cnt_nxt = dum_n_r;
								lanes = lane_release(W_SINGLE);
							end
							ST_RD: begin
								cnt_nxt = byte_clks(rd_w_r);
								lanes = lane_release(rd_w_r);
							end
							default: lanes = lane_release(W_SINGLE);
						endcase
						io_oe_nxt = lanes[7:4];
						io_o_nxt = lanes[3:0];
					end else if (state_r == ST_OPC || state_r == ST_PAY) begin
						lanes = lane_drive(sh_sh, cur_w);
						io_oe_nxt = lanes[7:4];
						io_o_nxt = lanes[3:0];
					end
				end
			end
			ST_END: begin
				div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
				if (tick) begin
					cs_n_nxt = 1'b1;
					wait_nxt = wait_len_r;
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Chip select stays high for the whole device delay
				if (wait_r <= 16'h0001) begin
					state_nxt = ST_IDLE;
					ready_nxt = 1'b1;
					done_nxt = 1'b1;
					pd_nxt = pd_after_r;
				end else begin
					wait_nxt = wait_r - 16'h0001;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cs_n_nxt = 1'b1;
				sck_nxt = 1'b0;
				ready_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			div_r <= 8'h00;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			io_o_r <= IO_IDLE_O;
			io_oe_r <= IO_IDLE_OE;
			sh_r <= 56'h0;
			cnt_r <= 6'h00;
			pay_n_r <= 6'h00;
			dum_n_r <= 6'h00;
			pay_w_r <= W_SINGLE;
			rd_w_r <= W_SINGLE;
			opw_r <= W_SINGLE;
			rd_en_r <= 1'b0;
			bytes_r <= 8'h00;
			rx_r <= 8'h00;
			wait_r <= 16'h0000;
			wait_len_r <= CS_HIGH_MIN_CYC;
			pd_r <= 1'b0;
			pd_after_r <= 1'b0;
			ready_r <= 1'b1;
			rsp_data_r <= 8'h00;
			rsp_valid_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			sck_r <= sck_nxt;
			cs_n_r <= cs_n_nxt;
			io_o_r <= io_o_nxt;
			io_oe_r <= io_oe_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			pay_n_r <= pay_n_nxt;
			dum_n_r <= dum_n_nxt;
			pay_w_r <= pay_w_nxt;
			rd_w_r <= rd_w_nxt;
			opw_r <= opw_nxt;
			rd_en_r <= rd_en_nxt;
			bytes_r <= bytes_nxt;
			rx_r <= rx_nxt;
			wait_r <= wait_nxt;
			wait_len_r <= wait_len_nxt;
			pd_r <= pd_nxt;
			pd_after_r <= pd_after_nxt;
			ready_r <= ready_nxt;
			rsp_data_r <= rsp_data_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
		end
	end

	assign cmd_ready = ready_r;
	assign rsp_data = rsp_data_r;
	assign rsp_valid = rsp_valid_r;
	assign done = done_r;
	assign cmd_err = err_r;
	assign powered_down = pd_r;
	assign spi_cs_n = cs_n_r;
	assign spi_sck = sck_r;
	assign spi_io_o = io_o_r;
	assign spi_io_oe = io_oe_r;

endmodule : fir_host

`default_nettype wire

// *** testbench/fir_flash_model.sv ***
/* Behavioural serial flash answering the identification commands.
   Assumes the bench resolves each lane from the host's output enables alone. */
`timescale 1ns/1ps
`default_nettype none
module fir_flash_model
	import fir_pkg::*;
#(
	parameter logic [7:0] MFR = 8'h00,
	parameter logic [7:0] DEV = 8'h00,
	parameter logic [7:0] TYP = 8'h00,
	parameter logic [7:0] CAP = 8'h00,
	parameter logic [63:0] UID = 64'h0
) (
	input wire logic cs_n,
	input wire logic sck,
	input wire logic qpi,
	input wire logic [3:0] io,
	output logic [3:0] io_drv
);
	logic [7:0] op = 8'h00;
	logic [63:0] sh = 64'h0;
	logic pd = 1'b0;
	logic ok = 1'b0;
	logic [7:0] d;
	int n = 0;
	int pre;
	int w;
	int p;
	longint wake = 0;
	initial io_drv = 4'h5;

	function automatic int pre_of(input logic [7:0] o, input logic q);
		case (o)
			OPC_RELEASE: return q ? 8 : 32;
			OPC_STD_ID: return q ? 2 : 8;
			OPC_MFR_ID: return q ? 0 : 32;
			OPC_MFR_ID_DUAL: return q ? 0 : 24;
			OPC_MFR_ID_QUAD: return q ? 0 : 20;
			OPC_UNIQUE_ID, OPC_PARAM_READ: return q ? 0 : 40;
			default: return 0;
		endcase
	endfunction : pre_of

	function automatic logic fmt_ok(input logic [7:0] o);
		case (o)
			OPC_MFR_ID: return sh[23:0] == 24'h0;
			OPC_MFR_ID_DUAL,
			OPC_MFR_ID_QUAD: return sh[31:8] == 24'h0 && sh[7:4] == 4'hf;
			OPC_PARAM_READ: return sh[23:8] == 16'h0;
			default: return 1'b1;
		endcase
	endfunction : fmt_ok

	function automatic logic [7:0] dat(input logic [7:0] o, input int k);
		case (o)
			OPC_RELEASE: return DEV;
			OPC_STD_ID: return k == 0 ? MFR : k == 1 ? TYP : CAP;
			OPC_UNIQUE_ID: return UID[63 - 8 * (k % 8) -: 8];
			OPC_PARAM_READ: return (sh[7:0] + 8'(k)) ^ 8'h3c;
			default: return k[0] ? DEV : MFR;
		endcase
	endfunction : dat

	always @(negedge cs_n) begin
		n = 0;
		op = 8'h00;
		sh = 64'h0;
		ok = $time >= wake;
	end

	always @(posedge sck) if (!cs_n) begin
		if (n < (qpi ? 2 : 8))
			op = qpi ? {op[3:0], io} : {op[6:0], io[0]};
		else if (op == OPC_MFR_ID_QUAD)
			sh = n < 20 ? {sh[59:0], io} : sh;
		else if (op == OPC_MFR_ID_DUAL)
			sh = n < 24 ? {sh[61:0], io[1:0]} : sh;
		else if (n < 32)
			sh = {sh[62:0], io[0]};
		n++;
	end

	// Released lanes toggle so a stale value is never read as data
	always @(negedge sck) begin
		pre = pre_of(op, qpi);
		w = qpi || op == OPC_MFR_ID_QUAD ? 4 : op == OPC_MFR_ID_DUAL ? 2 : 1;
		io_drv = ~io_drv;
		if (!cs_n && ok && pre != 0 && n >= pre && fmt_ok(op) &&
				(!pd || op == OPC_RELEASE)) begin
			p = (n - pre) * w;
			d = dat(op, p / 8);
			if (w == 4)
				io_drv = d[7 - p % 8 -: 4];
			else if (w == 2)
				io_drv[1:0] = d[7 - p % 8 -: 2];
			else
				io_drv[1] = d[7 - p % 8];
		end
	end

	always @(posedge cs_n) begin
		io_drv = ~io_drv;
		if (ok && op == OPC_POWER_DOWN && n == (qpi ? 2 : 8))
			pd = 1'b1;
		else if (ok && op == OPC_RELEASE && pd) begin
			pd = 1'b0;
			wake = $time + (n > (qpi ? 2 : 8) ? RELEASE_WITH_ID_DELAY_NS :
				POWER_UP_RELEASE_DELAY_NS);
		end
	end
endmodule : fir_flash_model
`default_nettype wire

// *** testbench/fir_host_chk.sv ***
/* Concurrent checks on the identification controller's ports.
   Assumes it is bound into fir_host; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module fir_host_chk
	import fir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [3:0] cmd_sel,
	input wire logic [7:0] cmd_len,
	input wire logic qpi_mode,
	input wire logic done,
	input wire logic cmd_err,
	input wire logic powered_down,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic [3:0] spi_io_o,
	input wire logic [3:0] spi_io_oe
);
	logic [15:0] hi_r, hi_nxt;
	logic [3:0] sel_r, sel_nxt;
	logic pd_r, pd_nxt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Cycles of chip select high, and the command last taken
	always_comb begin
		hi_nxt = spi_cs_n ? hi_r + {15'h0, hi_r != 16'hffff} : 16'h0;
		sel_nxt = cmd_valid && cmd_ready ? cmd_sel : sel_r;
		pd_nxt = cmd_valid && cmd_ready ? powered_down : pd_r;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hi_r <= 16'h0;
			sel_r <= 4'h0;
			pd_r <= 1'b0;
		end else begin
			hi_r <= hi_nxt;
			sel_r <= sel_nxt;
			pd_r <= pd_nxt;
		end
	end

	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_refused;
		cmd_err && cmd_ready && spi_cs_n;
	endsequence

	a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> spi_cs_n &&
		!spi_sck && spi_io_oe == IO_IDLE_OE && cmd_ready && !powered_down)
		else $error("outputs not idle after reset");
	a_bad_sel: assert property (s_take ##0 cmd_sel > 4'h8 |=> s_refused)
		else $error("out of range command not refused");
	a_pd_refuse: assert property (s_take ##0 powered_down &&
		cmd_sel != 4'h1 && cmd_sel != 4'h2 |=> s_refused)
		else $error("command in power-down not refused");
	a_qpi_refuse: assert property (s_take ##0 qpi_mode &&
		cmd_sel inside {4'h4, 4'h5, 4'h6, 4'h8} |=> s_refused)
		else $error("single-line command in four-line mode not refused");
	a_take_jedec: assert property (s_take ##0 cmd_sel == 4'h7 &&
		!powered_down && cmd_len != 8'h00 |=> !cmd_ready && !spi_cs_n &&
		spi_io_oe[0] && spi_io_o[0] == OPC_STD_ID[7])
		else $error("identification opcode not started");
	a_sck_idle: assert property (spi_cs_n |-> !spi_sck)
		else $error("serial clock active while deselected");
	a_cs_min_high: assert property (done |-> hi_r >= CS_HIGH_MIN_CYC)
		else $error("chip select high too short");
	a_release_hold: assert property (done && sel_r == 4'h1 |->
		hi_r >= POWER_UP_RELEASE_CYC)
		else $error("release wait too short");
	a_relid_hold: assert property (done && sel_r == 4'h2 && pd_r |->
		hi_r >= RELEASE_WITH_ID_CYC)
		else $error("release with id wait too short");
	a_pd_hold: assert property (done && sel_r == 4'h0 |->
		hi_r >= POWER_DOWN_ENTRY_CYC ##1 powered_down)
		else $error("power-down entry wait too short");
endmodule : fir_host_chk

bind fir_host fir_host_chk fir_host_chk_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_sel(cmd_sel), .cmd_len(cmd_len),
	.qpi_mode(qpi_mode), .done(done), .cmd_err(cmd_err),
	.powered_down(powered_down), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
	.spi_io_o(spi_io_o), .spi_io_oe(spi_io_oe)
);
`default_nettype wire

// *** testbench/fir_host_test.sv ***
/* Self-checking bench for fir_host against a behavioural flash.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`default_nettype none
module fir_host_test
	import fir_pkg::*;
	;
	// Identity values are arbitrary
	localparam logic [7:0] MFR = 8'h3a;
	localparam logic [7:0] DEV = 8'h15;
	localparam logic [7:0] TYP = 8'h40;
	localparam logic [7:0] CAP = 8'h16;
	localparam logic [63:0] UID = 64'h0123456789abcdef;
	typedef struct packed {
		logic [3:0] s;
		logic q;
		logic [7:0] a;
		logic [7:0] n;
		logic [63:0] e;
		logic er;
	} fir_row_s;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_sel = 4'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic qpi_mode = 1'b0;
	logic cmd_ready, rsp_valid, done, cmd_err, powered_down, spi_cs_n, spi_sck;
	logic [7:0] rsp_data;
	logic [3:0] spi_io_o, spi_io_oe, flash_io, lane;
	logic [7:0] got [$];
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	fir_row_s rows [0:15] = '{
		'{4'h7, 1'b0, 8'h00, 8'h03, {MFR, TYP, CAP, 40'h0}, 1'b0},
		'{4'h7, 1'b1, 8'h00, 8'h03, {MFR, TYP, CAP, 40'h0}, 1'b0},
		'{4'h2, 1'b0, 8'h00, 8'h03, {DEV, DEV, DEV, 40'h0}, 1'b0},
		'{4'h2, 1'b1, 8'h00, 8'h02, {DEV, DEV, 48'h0}, 1'b0},
		'{4'h3, 1'b0, 8'h00, 8'h02, {MFR, DEV, 48'h0}, 1'b0},
		'{4'h4, 1'b0, 8'h00, 8'h04, {MFR, DEV, MFR, DEV, 32'h0}, 1'b0},
		'{4'h5, 1'b0, 8'h00, 8'h04, {MFR, DEV, MFR, DEV, 32'h0}, 1'b0},
		'{4'h6, 1'b0, 8'h00, 8'h08, UID, 1'b0},
		'{4'h8, 1'b0, 8'h10, 8'h02, {8'h2c, 8'h2d, 48'h0}, 1'b0},
		'{4'h8, 1'b0, 8'hff, 8'h01, {8'hc3, 56'h0}, 1'b0},
		'{4'h9, 1'b0, 8'h00, 8'h01, 64'h0, 1'b1},
		'{4'h4, 1'b1, 8'h00, 8'h04, 64'h0, 1'b1},
		'{4'h5, 1'b1, 8'h00, 8'h04, 64'h0, 1'b1},
		'{4'h6, 1'b1, 8'h00, 8'h08, 64'h0, 1'b1},
		'{4'h8, 1'b1, 8'h00, 8'h01, 64'h0, 1'b1},
		'{4'h7, 1'b0, 8'h00, 8'h00, 64'h0, 1'b1}
	};

	fir_host fir_host_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .qpi_mode(qpi_mode), .rsp_data(rsp_data),
		.rsp_valid(rsp_valid), .done(done), .cmd_err(cmd_err),
		.powered_down(powered_down), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_io_o(spi_io_o), .spi_io_oe(spi_io_oe), .spi_io_i(lane)
	);
	fir_flash_model #(.MFR(MFR), .DEV(DEV), .TYP(TYP), .CAP(CAP), .UID(UID))
		fir_flash_model_i (.cs_n(spi_cs_n), .sck(spi_sck), .qpi(qpi_mode),
		.io(lane), .io_drv(flash_io));
	assign lane = (spi_io_oe & spi_io_o) | (~spi_io_oe & flash_io);

	always #25 clk_sys = ~clk_sys;
	always @(negedge clk_sys) if (rsp_valid === 1'b1) got.push_back(rsp_data);

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic issue(input fir_row_s r);
		@(negedge clk_sys);
		cmd_sel = r.s;
		qpi_mode = r.q;
		cmd_addr = r.a;
		cmd_len = r.n;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask : issue

	task automatic run(input fir_row_s r);
		int t;
		got.delete();
		issue(r);
		t = 0;
		while (done !== 1'b1 && cmd_err !== 1'b1 && t < 5000) begin
			@(negedge clk_sys);
			t++;
		end
		check(64'(cmd_err), 64'(r.er));
		check(64'(got.size()), r.er ? 64'h0 : 64'(r.n));
		for (int i = 0; i < got.size(); i++)
			check(64'(got[i]), 64'(r.e[63 - 8 * i -: 8]));
	endtask : run

	initial begin
		repeat (10) @(negedge clk_sys);
		check(64'({spi_cs_n, spi_sck, spi_io_oe, spi_io_o, cmd_ready,
			powered_down}), 64'hb32);
		rst_n = 1'b1;
		for (int i = 0; i < 16; i++)
			run(rows[i]);
		run('{4'h0, 1'b0, 8'h00, 8'h00, 64'h0, 1'b0});
		check(64'(powered_down), 64'h1);
		run('{4'h7, 1'b0, 8'h00, 8'h03, 64'h0, 1'b1});
		run('{4'h1, 1'b0, 8'h00, 8'h00, 64'h0, 1'b0});
		check(64'(powered_down), 64'h0);
		run(rows[0]);
		run('{4'h0, 1'b0, 8'h00, 8'h00, 64'h0, 1'b0});
		run('{4'h2, 1'b0, 8'h00, 8'h02, {DEV, DEV, 48'h0}, 1'b0});
		run(rows[1]);
		issue(rows[7]);
		repeat (200) @(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(64'({spi_cs_n, cmd_ready, rsp_valid}), 64'h6);
		rst_n = 1'b1;
		run(rows[7]);
		tally_and_finish();
	end
endmodule : fir_host_test
`default_nettype wire
